// file: include/vic_pkg.sv
// Constants shared by the interrupt controller command and status block.
package vic_pkg;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned NUM_SRC = 32;

  // Register byte offsets.
  localparam logic [7:0] OFF_PENDING    = 8'h00;
  localparam logic [7:0] OFF_MASK       = 8'h04;
  localparam logic [7:0] OFF_CORE_LINE  = 8'h08;
  localparam logic [7:0] OFF_ENABLE     = 8'h0C;
  localparam logic [7:0] OFF_DISABLE    = 8'h10;
  localparam logic [7:0] OFF_CLEAR      = 8'h14;
  localparam logic [7:0] OFF_SET        = 8'h18;
  localparam logic [7:0] OFF_END_SVC    = 8'h1C;
  localparam logic [7:0] OFF_SPURIOUS   = 8'h20;
  localparam logic [7:0] OFF_DEBUG      = 8'h24;
  localparam logic [7:0] OFF_FF_ENABLE  = 8'h28;
  localparam logic [7:0] OFF_FF_DISABLE = 8'h2C;
  localparam logic [7:0] OFF_FF_STATUS  = 8'h30;

  // Source bit positions.
  localparam int unsigned BIT_FAST_SRC = 0;
  localparam int unsigned BIT_SYS_SRC  = 1;

  // Core line status fields.
  localparam int unsigned BIT_FAST_LINE   = 0;
  localparam int unsigned BIT_NORMAL_LINE = 1;

  // Debug control fields.
  localparam int unsigned BIT_PROTECT = 0;
  localparam int unsigned BIT_GMASK   = 1;

  // Reset values.
  localparam logic [31:0] RST_MASK     = 32'h0000_0000;
  localparam logic [31:0] RST_PENDING  = 32'h0000_0000;
  localparam logic [31:0] RST_SPURIOUS = 32'h0000_0000;
  localparam logic [1:0]  RST_DEBUG    = 2'h0;
  localparam logic [31:0] RST_FF       = 32'h0000_0000;

  // Fast forcing has no meaning on the fast source itself.
  localparam logic [31:0] FF_VALID = 32'hFFFF_FFFE;

endpackage

// file: design/vic_line_gen.sv
// Generates the registered fast and normal processor request line states.
`timescale 1ns/1ps
module vic_line_gen (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [31:0] pending,
  input  wire logic [31:0] mask,
  input  wire logic [31:0] fastForce,
  input  wire logic        globalMask,
  input  wire logic        inService,
  output logic             fastActive,
  output logic             normalActive
);

  logic [31:0] live;
  logic        next_fast;
  logic        next_normal;

  always_comb begin
    live = pending & mask;
    // The fast source and any forced source drive the fast line.
    next_fast = live[vic_pkg::BIT_FAST_SRC]
                | (|(live & fastForce & vic_pkg::FF_VALID));
    // A normal request waits until the current one is serviced.
    next_normal = (|(live & ~fastForce & vic_pkg::FF_VALID)) & ~inService;
    if (globalMask) begin
      next_fast   = 1'b0;
      next_normal = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fastActive   <= 1'b0;
      normalActive <= 1'b0;
    end else begin
      fastActive   <= next_fast;
      normalActive <= next_normal;
    end
  end

endmodule

// file: design/vic_cmd_status.sv
// Command and status registers of the vectored interrupt controller.
`timescale 1ns/1ps
// Summary of operation
// - Bit 0 is fast source, bit 1 system, bits 2-31 peripherals.
// - Pending register reads 1 for each pending source.
// - Mask status reads 1 per enabled source, clears at reset.
// - Core line status bit 0 shows the fast request line.
// - Core line status bit 1 shows the normal request line.
// - Enable command ones enable sources, zeros leave mask alone.
// - Disable command ones disable sources, zeros do nothing.
// - Clear command ones clear pending interrupts.
// - Set command ones set pending interrupts by software.
// - Any write to end of service signals end of interrupt.
// - Spurious vector is read/write, resets to zero, fed to vectors.
// - Debug bit 0 enables protection mode, resets to zero.
// - Debug bit 1 holds both request lines inactive.
// - Fast force enable ones on bits 1-31 enable forcing.
// - Fast force disable ones on bits 1-31 disable forcing.
// - Fast force status shows which sources are forced.
module vic_cmd_status (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  output logic      [31:0] rdData,
  input  wire logic [31:0] srcIn,
  input  wire logic        normalVectorRead,
  output logic             fastReqLineN,
  output logic             normalReqLineN,
  output logic      [31:0] spuriousVectorValue,
  output logic             protectionEnable,
  output logic             endOfServicePulse,
  output logic             inService
);

  // Returns cur with every bit that is high in clr forced low.
  function automatic logic [31:0] applyClr(
    input logic [31:0] cur,
    input logic [31:0] clr
  );
    applyClr = cur & ~clr;
  endfunction

  function automatic logic [31:0] applySet(
    input logic [31:0] cur,
    input logic [31:0] set
  );
    applySet = cur | set;
  endfunction

  function automatic logic isWrite(
    input logic       strobe,
    input logic [7:0] a,
    input logic [7:0] off
  );
    isWrite = strobe && (a == off);
  endfunction

  logic [31:0] mask;
  logic [31:0] pending;
  logic [31:0] fastForce;
  logic [31:0] spurious;
  logic [1:0]  debugCtl;
  logic        fastActive;
  logic        normalActive;

  logic        wrEnable;
  logic        wrDisable;
  logic        wrClear;
  logic        wrSet;
  logic        wrEndSvc;
  logic        wrSpurious;
  logic        wrDebug;
  logic        wrFfEnable;
  logic        wrFfDisable;
  logic [31:0] next_rdData;

  always_comb begin
    wrEnable    = isWrite(wrStrobe, addr, vic_pkg::OFF_ENABLE);
    wrDisable   = isWrite(wrStrobe, addr, vic_pkg::OFF_DISABLE);
    wrClear     = isWrite(wrStrobe, addr, vic_pkg::OFF_CLEAR);
    wrSet       = isWrite(wrStrobe, addr, vic_pkg::OFF_SET);
    wrEndSvc    = isWrite(wrStrobe, addr, vic_pkg::OFF_END_SVC);
    wrSpurious  = isWrite(wrStrobe, addr, vic_pkg::OFF_SPURIOUS);
    wrDebug     = isWrite(wrStrobe, addr, vic_pkg::OFF_DEBUG);
    wrFfEnable  = isWrite(wrStrobe, addr, vic_pkg::OFF_FF_ENABLE);
    wrFfDisable = isWrite(wrStrobe, addr, vic_pkg::OFF_FF_DISABLE);
  end

  // Source mask, one bit per source in the common source layout.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mask <= vic_pkg::RST_MASK;
    end else if (wrEnable) begin
      mask <= applySet(mask, wrData);
    end else if (wrDisable) begin
      mask <= applyClr(mask, wrData);
    end
  end

  // Pending flags. A source that is asserting in the cycle of a clear
  // keeps its flag, so no event is lost to a racing clear.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pending <= vic_pkg::RST_PENDING;
    end else begin
      pending <= applySet(
                   applySet(
                     applyClr(pending, wrClear ? wrData : 32'h0000_0000),
                     wrSet ? wrData : 32'h0000_0000),
                   srcIn);
    end
  end

  // Fast forcing selection; bit 0 stays zero.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fastForce <= vic_pkg::RST_FF;
    end else if (wrFfEnable) begin
      fastForce <= applySet(fastForce,
                            wrData & vic_pkg::FF_VALID);
    end else if (wrFfDisable) begin
      fastForce <= applyClr(fastForce,
                            wrData & vic_pkg::FF_VALID);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      spurious <= vic_pkg::RST_SPURIOUS;
    end else if (wrSpurious) begin
      spurious <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      debugCtl <= vic_pkg::RST_DEBUG;
    end else if (wrDebug) begin
      debugCtl <= wrData[1:0];
    end
  end

  // End of service: any data value counts. A vector read in the same
  // cycle starts a new service period and wins.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      inService <= 1'b0;
    end else if (normalVectorRead) begin
      inService <= 1'b1;
    end else if (wrEndSvc) begin
      inService <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      endOfServicePulse <= 1'b0;
    end else begin
      endOfServicePulse <= wrEndSvc;
    end
  end

  vic_line_gen u_line_gen (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .pending      (pending),
    .mask         (mask),
    .fastForce    (fastForce),
    .globalMask   (debugCtl[vic_pkg::BIT_GMASK]),
    .inService    (inService),
    .fastActive   (fastActive),
    .normalActive (normalActive)
  );

  // Request lines are active low toward the processor.
  assign fastReqLineN        = ~fastActive;
  assign normalReqLineN      = ~normalActive;
  assign spuriousVectorValue = spurious;
  assign protectionEnable    = debugCtl[vic_pkg::BIT_PROTECT];

  // Read mux. Command locations and unmapped offsets read as zero.
  always_comb begin
    next_rdData = 32'h0000_0000;
    if (addr == vic_pkg::OFF_PENDING) begin
      next_rdData = pending;
    end else if (addr == vic_pkg::OFF_MASK) begin
      next_rdData = mask;
    end else if (addr == vic_pkg::OFF_CORE_LINE) begin
      next_rdData[vic_pkg::BIT_FAST_LINE]   = fastActive;
      next_rdData[vic_pkg::BIT_NORMAL_LINE] = normalActive;
    end else if (addr == vic_pkg::OFF_SPURIOUS) begin
      next_rdData = spurious;
    end else if (addr == vic_pkg::OFF_DEBUG) begin
      next_rdData[1:0] = debugCtl;
    end else if (addr == vic_pkg::OFF_FF_STATUS) begin
      next_rdData = fastForce;
    end else begin
      next_rdData = 32'h0000_0000;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdData <= 32'h0000_0000;
    end else if (rdStrobe) begin
      rdData <= next_rdData;
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_enable_sets: assert property (
    wrEnable |=> ((mask & $past(wrData)) == $past(wrData))
                 && ((mask & ~$past(wrData))
                     == ($past(mask) & ~$past(wrData))))
    else $error("Enable command did not update the mask.");

  a_disable_clears: assert property (
    wrDisable |=> ((mask & $past(wrData)) == 32'h0000_0000)
                  && ((mask & ~$past(wrData))
                      == ($past(mask) & ~$past(wrData))))
    else $error("Disable command did not update the mask.");

  a_clear_pending: assert property (
    wrClear && !wrSet
    |=> ((pending & $past(wrData) & ~$past(srcIn)) == 32'h0000_0000))
    else $error("Clear command left a pending flag set.");

  a_set_pending: assert property (
    wrSet |=> ((pending & $past(wrData)) == $past(wrData)))
    else $error("Set command did not raise pending flags.");

  a_status_ro: assert property (
    wrStrobe && (addr == vic_pkg::OFF_MASK
                 || addr == vic_pkg::OFF_FF_STATUS)
    |=> $stable(mask) && $stable(fastForce))
    else $error("Write to a status register changed state.");

  a_cmd_read_zero: assert property (
    rdStrobe && (addr == vic_pkg::OFF_ENABLE
                 || addr == vic_pkg::OFF_SET
                 || addr == vic_pkg::OFF_END_SVC)
    |=> rdData == 32'h0000_0000)
    else $error("Command register read returned nonzero data.");

  a_core_status: assert property (
    rdStrobe && addr == vic_pkg::OFF_CORE_LINE
    |=> rdData == {30'h0, $past(normalActive),
                   $past(fastActive)})
    else $error("Core line status disagrees with the lines.");

  a_gmask_lines: assert property (
    debugCtl[vic_pkg::BIT_GMASK] ##1 debugCtl[vic_pkg::BIT_GMASK]
    |-> fastReqLineN && normalReqLineN)
    else $error("Request line active under the global mask.");

  a_ff_bit0: assert property (
    fastForce[vic_pkg::BIT_FAST_SRC] == 1'b0)
    else $error("Fast forcing set on the fast source bit.");

  a_ff_status_read: assert property (
    rdStrobe && addr == vic_pkg::OFF_FF_STATUS
    |=> rdData == $past(fastForce))
    else $error("Fast force status read mismatch.");

  a_end_service: assert property (
    wrEndSvc && !normalVectorRead |=> !inService && endOfServicePulse)
    else $error("End of service write had no effect.");

  a_eos_pulse: assert property (
    !wrEndSvc |=> !endOfServicePulse)
    else $error("End of service pulse without a write.");

  a_service_start: assert property (
    normalVectorRead |=> inService)
    else $error("Vector read did not start a service period.");

  a_spurious_held: assert property (
    wrSpurious |=> spuriousVectorValue == $past(wrData))
    else $error("Spurious vector not stored.");

  a_spurious_read: assert property (
    rdStrobe && addr == vic_pkg::OFF_SPURIOUS
    |=> rdData == $past(spurious))
    else $error("Spurious vector read mismatch.");

  a_pending_src: assert property (
    (|srcIn) |=> (pending & $past(srcIn)) == $past(srcIn))
    else $error("Asserting source did not become pending.");

  a_pending_read: assert property (
    rdStrobe && addr == vic_pkg::OFF_PENDING
    |=> rdData == $past(pending))
    else $error("Pending status read mismatch.");

  a_mask_read: assert property (
    rdStrobe && addr == vic_pkg::OFF_MASK
    |=> rdData == $past(mask))
    else $error("Mask status read mismatch.");

  a_debug_read: assert property (
    rdStrobe && addr == vic_pkg::OFF_DEBUG
    |=> rdData == {30'h0, $past(debugCtl)})
    else $error("Debug control read mismatch.");

  a_ff_enable: assert property (
    wrFfEnable
    |=> (fastForce & $past(wrData) & vic_pkg::FF_VALID)
        == ($past(wrData) & vic_pkg::FF_VALID))
    else $error("Fast force enable did not take effect.");

  a_ff_disable: assert property (
    wrFfDisable |=> (fastForce & $past(wrData)) == 32'h0000_0000)
    else $error("Fast force disable did not take effect.");

  a_fast_line: assert property (
    !debugCtl[vic_pkg::BIT_GMASK] && pending[vic_pkg::BIT_FAST_SRC]
    && mask[vic_pkg::BIT_FAST_SRC] |=> !fastReqLineN)
    else $error("Enabled fast source did not drive the fast line.");

  a_normal_line: assert property (
    !debugCtl[vic_pkg::BIT_GMASK] && !inService
    && (|(pending & mask & ~fastForce & vic_pkg::FF_VALID))
    |=> !normalReqLineN)
    else $error("Enabled source did not drive the normal line.");

  a_forced_line: assert property (
    !debugCtl[vic_pkg::BIT_GMASK]
    && (|(pending & mask & fastForce & vic_pkg::FF_VALID))
    |=> !fastReqLineN)
    else $error("Forced source did not drive the fast line.");

  a_rd_idle: assert property (
    !rdStrobe |=> rdData == 32'h0000_0000)
    else $error("Read data present without a read strobe.");

  c_fast_line: cover property (
    wrSet && wrData[vic_pkg::BIT_FAST_SRC] ##[1:4] !fastReqLineN);

  c_normal_service: cover property (
    !normalReqLineN ##[1:8] normalVectorRead ##[1:8] wrEndSvc);

  c_forced_fast: cover property (
    wrSet ##2 (!fastReqLineN && (|(pending & fastForce))));

  c_gmask_set: cover property (
    wrDebug && wrData[vic_pkg::BIT_GMASK]);

endmodule

// file: testbench/vic_core_model.sv
// Processor core model that answers the normal request line.
`timescale 1ns/1ps
module vic_core_model (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       normalReqLineN,
  input  wire logic       ackGo,
  input  wire logic [3:0] ackDelay,
  output logic            normalVectorRead
);
  logic [3:0] waitCnt;
  logic       armed;

  // One vector read per assertion of the line, after ackDelay cycles.
  always_ff @(posedge core_clk) begin
    if (!nrst || normalReqLineN) begin
      normalVectorRead <= 1'b0;
      waitCnt          <= 4'h0;
      armed            <= 1'b1;
    end else if (armed && ackGo && waitCnt == ackDelay) begin
      normalVectorRead <= 1'b1;
      armed            <= 1'b0;
    end else begin
      normalVectorRead <= 1'b0;
      if (armed && ackGo) begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule

// file: testbench/test_vic_cmd_status.sv
// Register level testbench of the interrupt command and status block.
`timescale 1ns/1ps
module test_vic_cmd_status;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic        wrStrobe = 1'b0;
  logic        rdStrobe = 1'b0;
  logic [31:0] rdData;
  logic [31:0] srcIn = 32'h0;
  logic        normalVectorRead;
  logic        fastReqLineN;
  logic        normalReqLineN;
  logic [31:0] spuriousVectorValue;
  logic        protectionEnable;
  logic        endOfServicePulse;
  logic        inService;
  logic        ackGo = 1'b0;
  logic [3:0]  ackDelay = 4'h0;
  int          miscompares = 0;
  int          checked = 0;
  logic [7:0]  offs [8];

  vic_cmd_status dut (
    .core_clk(core_clk), .nrst(nrst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .srcIn(srcIn), .normalVectorRead(normalVectorRead),
    .fastReqLineN(fastReqLineN), .normalReqLineN(normalReqLineN),
    .spuriousVectorValue(spuriousVectorValue),
    .protectionEnable(protectionEnable),
    .endOfServicePulse(endOfServicePulse), .inService(inService)
  );

  vic_core_model core (
    .core_clk(core_clk), .nrst(nrst), .normalReqLineN(normalReqLineN),
    .ackGo(ackGo), .ackDelay(ackDelay),
    .normalVectorRead(normalVectorRead)
  );

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    wrStrobe <= 1'b1;
    addr     <= a;
    wrData   <= d;
    @(posedge core_clk);
    wrStrobe <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge core_clk);
    rdStrobe <= 1'b1;
    addr     <= a;
    @(posedge core_clk);
    rdStrobe <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdData, exp);
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    offs = '{vic_pkg::OFF_PENDING, vic_pkg::OFF_MASK, vic_pkg::OFF_CORE_LINE,
      vic_pkg::OFF_SPURIOUS, vic_pkg::OFF_DEBUG, vic_pkg::OFF_FF_STATUS,
      vic_pkg::OFF_PENDING, vic_pkg::OFF_MASK};
    foreach (offs[i]) rd(offs[i], 32'h0);
    chk("lines", {30'h0, fastReqLineN, normalReqLineN}, 32'h3);
    wr(vic_pkg::OFF_ENABLE, 32'h0000_0005);
    wr(vic_pkg::OFF_ENABLE, 32'h8000_0000);
    wr(vic_pkg::OFF_ENABLE, 32'h0);
    rd(vic_pkg::OFF_MASK, 32'h8000_0005);
    wr(vic_pkg::OFF_DISABLE, 32'h0000_0004);
    wr(vic_pkg::OFF_DISABLE, 32'h0);
    rd(vic_pkg::OFF_MASK, 32'h8000_0001);
    wr(vic_pkg::OFF_MASK, 32'hFFFF_FFFF);
    rd(vic_pkg::OFF_MASK, 32'h8000_0001);
    offs = '{vic_pkg::OFF_ENABLE, vic_pkg::OFF_DISABLE, vic_pkg::OFF_CLEAR,
      vic_pkg::OFF_SET, vic_pkg::OFF_END_SVC, vic_pkg::OFF_FF_ENABLE,
      vic_pkg::OFF_FF_DISABLE, 8'hFC};
    foreach (offs[i]) rd(offs[i], 32'h0);
    wr(vic_pkg::OFF_SET, 32'h0000_0006);
    rd(vic_pkg::OFF_PENDING, 32'h0000_0006);
    wr(vic_pkg::OFF_CLEAR, 32'h0000_0002);
    wr(vic_pkg::OFF_CLEAR, 32'h0);
    rd(vic_pkg::OFF_PENDING, 32'h0000_0004);
    wr(vic_pkg::OFF_CLEAR, 32'h0000_0004);
    @(posedge core_clk);
    srcIn <= 32'h0000_0020;
    @(posedge core_clk);
    srcIn <= 32'h0;
    rd(vic_pkg::OFF_PENDING, 32'h0000_0020);
    wr(vic_pkg::OFF_CLEAR, 32'h0000_0020);
    wr(vic_pkg::OFF_SET, 32'h0000_0001);
    rd(vic_pkg::OFF_CORE_LINE, 32'h0000_0001);
    chk("fast line", {31'h0, fastReqLineN}, 32'h0);
    wr(vic_pkg::OFF_CLEAR, 32'h0000_0001);
    rd(vic_pkg::OFF_CORE_LINE, 32'h0);
    chk("fast line", {31'h0, fastReqLineN}, 32'h1);
    // The core answers once promptly and once late.
    for (int d = 0; d < 8; d += 4) begin
      @(posedge core_clk);
      ackGo    <= 1'b1;
      ackDelay <= 4'(d);
      wr(vic_pkg::OFF_SET, 32'h8000_0000);
      rd(vic_pkg::OFF_CORE_LINE, 32'h0000_0002);
      chk("normal line", {31'h0, normalReqLineN}, 32'h0);
      for (int k = 0; k < 20 && inService !== 1'b1; k++) cyc(1);
      chk("in service", {31'h0, inService}, 32'h1);
      if (inService !== 1'b1) stop_test();
      @(posedge core_clk);
      ackGo <= 1'b0;
      wr(vic_pkg::OFF_END_SVC, 32'(d));
      #1;
      chk("eos", {30'h0, endOfServicePulse, inService}, 32'h2);
      cyc(1);
      chk("eos end", {31'h0, endOfServicePulse}, 32'h0);
      wr(vic_pkg::OFF_CLEAR, 32'h8000_0000);
    end
    wr(vic_pkg::OFF_SET, 32'h0000_0001);
    wr(vic_pkg::OFF_DEBUG, 32'h0000_0002);
    rd(vic_pkg::OFF_CORE_LINE, 32'h0);
    chk("fast line", {31'h0, fastReqLineN}, 32'h1);
    rd(vic_pkg::OFF_DEBUG, 32'h0000_0002);
    wr(vic_pkg::OFF_DEBUG, 32'h0000_0001);
    rd(vic_pkg::OFF_DEBUG, 32'h0000_0001);
    chk("protect", {31'h0, protectionEnable}, 32'h1);
    rd(vic_pkg::OFF_CORE_LINE, 32'h0000_0001);
    wr(vic_pkg::OFF_DEBUG, 32'h0);
    wr(vic_pkg::OFF_CLEAR, 32'h0000_0001);
    chk("protect", {31'h0, protectionEnable}, 32'h0);
    wr(vic_pkg::OFF_SPURIOUS, 32'hA5C3_0F96);
    rd(vic_pkg::OFF_SPURIOUS, 32'hA5C3_0F96);
    chk("spurious", spuriousVectorValue, 32'hA5C3_0F96);
    wr(vic_pkg::OFF_FF_ENABLE, 32'hFFFF_FFFF);
    rd(vic_pkg::OFF_FF_STATUS, 32'hFFFF_FFFE);
    wr(vic_pkg::OFF_FF_DISABLE, 32'h0000_0005);
    rd(vic_pkg::OFF_FF_STATUS, 32'hFFFF_FFFA);
    wr(vic_pkg::OFF_FF_STATUS, 32'h0);
    rd(vic_pkg::OFF_FF_STATUS, 32'hFFFF_FFFA);
    wr(vic_pkg::OFF_ENABLE, 32'h0000_0008);
    wr(vic_pkg::OFF_SET, 32'h0000_0008);
    rd(vic_pkg::OFF_CORE_LINE, 32'h0000_0001);
    wr(vic_pkg::OFF_FF_DISABLE, 32'hFFFF_FFFF);
    rd(vic_pkg::OFF_CORE_LINE, 32'h0000_0002);
    rd(vic_pkg::OFF_FF_STATUS, 32'h0);
    wr(vic_pkg::OFF_CLEAR, 32'h0000_0008);
    // A second reset with live state must bring every register to zero.
    wr(vic_pkg::OFF_DEBUG, 32'h0000_0001);
    wr(vic_pkg::OFF_SET, 32'h8000_0000);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(vic_pkg::OFF_MASK, 32'h0);
    rd(vic_pkg::OFF_PENDING, 32'h0);
    rd(vic_pkg::OFF_SPURIOUS, 32'h0);
    rd(vic_pkg::OFF_DEBUG, 32'h0);
    chk("lines", {30'h0, fastReqLineN, normalReqLineN}, 32'h3);
    stop_test();
  end
endmodule
